// ---- tx_pkg.sv ----
package tx_pkg;

   // ----------------------------------------------------------------
   // widths and sizes
   // ----------------------------------------------------------------
   localparam int BAUD_W = 12;
   localparam int DATA_W = 9;
   localparam int FRAME_W = 13;
   localparam int COUNT_W = 4;
   localparam int FIFO_DEPTH = 16;

   // ----------------------------------------------------------------
   // frame format codes and timing counts
   // ----------------------------------------------------------------
   localparam logic [2:0] CS_NINE = 3'h7;
   localparam logic [3:0] CHAR_NINE = 4'h9;
   localparam logic [3:0] CHAR_MIN = 4'h5;
   localparam logic [3:0] START_BITS = 4'h1;
   localparam int OVERSAMPLE_NORMAL = 16;
   localparam int OVERSAMPLE_DOUBLE = 8;
   localparam logic [3:0] SUB_LAST_NORMAL = 4'(OVERSAMPLE_NORMAL - 1);
   localparam logic [3:0] SUB_LAST_DOUBLE = 4'(OVERSAMPLE_DOUBLE - 1);

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [FRAME_W-1:0] FRAME_IDLE = 13'h1fff;
   localparam logic [2:0] SYNC_RESET = 3'h0;

   typedef enum logic [0:0]
   {
      st_idle = 1'b0,
      st_shift = 1'b1
   } tx_state_type;

   typedef struct packed
   {
      logic transmitter_on_bit;
      logic sync_mode;
      logic sync_master;
      logic [2:0] char_size;
      logic parity_enable_bit;
      logic parity_odd;
      logic two_stop;
      logic double_speed_bit;
      logic clock_polarity_bit;
      logic [BAUD_W-1:0] baud_divisor;
      logic buffer_empty_irq_enable;
      logic tx_complete_irq_enable;
   } tx_config_type;

   typedef struct packed
   {
      tx_state_type state;
      logic [FRAME_W-1:0] frame;
      logic [COUNT_W-1:0] bits_left;
      logic buf_valid;
      logic [DATA_W-1:0] buf_data;
      logic [BAUD_W-1:0] presc;
      logic [3:0] sub;
      logic xck;
      logic txc;
      logic enabled;
      logic [2:0] xck_sync;
   } tx_core_type;

endpackage

// ---- tx_fifo.sv ----
`timescale 1ns/1ps
module tx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
)(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_state_type;

   fifo_state_type q_ff;
   fifo_state_type nxt_q;
   logic full;
   logic empty;

   // ----------------------------------------------------------------
   // pointers carry one extra bit so full and empty stay distinct
   // ----------------------------------------------------------------
   assign full = (q_ff.wr[AW] != q_ff.rd[AW]) &&
                 (q_ff.wr[AW-1:0] == q_ff.rd[AW-1:0]);
   assign empty = (q_ff.wr == q_ff.rd);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = q_ff.mem[q_ff.rd[AW-1:0]];

   always_comb
   begin
      nxt_q = q_ff;
      if (i_in_valid && !full)
      begin
         nxt_q.mem[q_ff.wr[AW-1:0]] = i_in_data;
         nxt_q.wr = q_ff.wr + 1'b1;
      end
      if (i_out_ready && !empty)
      begin
         nxt_q.rd = q_ff.rd + 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         q_ff <= '0;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

endmodule

// ---- serial_frame_transmitter.sv ----
`timescale 1ns/1ps
module serial_frame_transmitter (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire tx_pkg::tx_config_type i_cfg,
   input wire logic i_wr_valid,
   input wire logic [7:0] i_wr_data,
   output logic o_wr_ready,
   input wire logic i_tx_ninth_bit,
   input wire logic i_txc_clear,
   input wire logic i_txc_irq_ack,
   input wire logic i_transfer_clock_pin,
   output logic o_serial_out_pin,
   output logic o_serial_out_oe,
   output logic o_transfer_clock_out,
   output logic o_transfer_clock_oe,
   output logic o_tx_buffer_empty_flag,
   output logic o_tx_complete_flag,
   output logic o_buffer_empty_irq,
   output logic o_tx_complete_irq,
   output logic o_tx_active
);
   import tx_pkg::*;

   tx_core_type q_ff;
   tx_core_type nxt_q;
   logic fifo_out_valid;
   logic [DATA_W-1:0] fifo_out_data;
   logic fifo_out_ready;
   logic [DATA_W-1:0] wr_word;

   // ----------------------------------------------------------------
   // frame assembly
   // ----------------------------------------------------------------
   function automatic logic [3:0] char_bits(input tx_config_type c);
      logic [3:0] n;
      n = (c.char_size == CS_NINE) ? CHAR_NINE
                                   : CHAR_MIN + {2'h0, c.char_size[1:0]};
      return n;
   endfunction

   function automatic logic [FRAME_W-1:0] build_frame(
      input logic [DATA_W-1:0] d,
      input tx_config_type c
   );
      logic [FRAME_W-1:0] f;
      logic [3:0] n;
      logic p;
      n = char_bits(c);
      f = FRAME_IDLE;
      f[0] = 1'b0;
      p = c.parity_odd;
      for (int i = 0; i < DATA_W; i++)
      begin
         if (4'(i) < n)
         begin
            f[i + 1] = d[i];
            p = p ^ d[i];
         end
      end
      if (c.parity_enable_bit)
      begin
         f[n + 4'h1] = p;
      end
      return f;
   endfunction

   function automatic logic [3:0] frame_len(input tx_config_type c);
      logic [3:0] len;
      len = START_BITS + char_bits(c) + {3'h0, c.parity_enable_bit} +
            4'h1 + {3'h0, c.two_stop};
      return len;
   endfunction

   // ----------------------------------------------------------------
   // write path: buffered so bursts can queue; ninth bit rides along
   // ----------------------------------------------------------------
   assign wr_word = {i_tx_ninth_bit, i_wr_data};

   tx_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_in_valid(i_wr_valid),
      .i_in_data(wr_word),
      .o_in_ready(o_wr_ready),
      .o_out_valid(fifo_out_valid),
      .o_out_data(fifo_out_data),
      .i_out_ready(fifo_out_ready)
   );

   assign fifo_out_ready = !q_ff.buf_valid;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic div_tick;
      logic bit_tick;
      logic load;
      logic rise;
      logic fall;
      rise = 1'b0;
      fall = 1'b0;
      div_tick = 1'b0;
      bit_tick = 1'b0;
      load = 1'b0;
      nxt_q = q_ff;

      // only stages two and three feed the edge detector
      // slave edges land three cycles late: keep the pin under a quarter
      nxt_q.xck_sync = {q_ff.xck_sync[1:0], i_transfer_clock_pin};
      rise = q_ff.xck_sync[1] & ~q_ff.xck_sync[2];
      fall = ~q_ff.xck_sync[1] & q_ff.xck_sync[2];

      // divider gives a one-cycle enable rather than a second clock
      if (q_ff.presc == '0)
      begin
         nxt_q.presc = i_cfg.baud_divisor;
         div_tick = 1'b1;
      end
      else
      begin
         nxt_q.presc = q_ff.presc - 1'b1;
      end

      if (!i_cfg.sync_mode)
      begin
         if (div_tick)
         begin
            if (q_ff.sub == (i_cfg.double_speed_bit ? SUB_LAST_DOUBLE
                                                    : SUB_LAST_NORMAL))
            begin
               nxt_q.sub = 4'h0;
               bit_tick = 1'b1;
            end
            else
            begin
               nxt_q.sub = q_ff.sub + 1'b1;
            end
         end
      end
      else if (i_cfg.sync_master)
      begin
         if (div_tick)
         begin
            nxt_q.xck = ~q_ff.xck;
            bit_tick = ~q_ff.xck ^ i_cfg.clock_polarity_bit;
         end
      end
      else
      begin
         bit_tick = i_cfg.clock_polarity_bit ? fall : rise;
      end

      // parked clock sits at the level whose next edge changes data
      if (!(q_ff.enabled && i_cfg.sync_mode && i_cfg.sync_master))
      begin
         nxt_q.xck = i_cfg.clock_polarity_bit;
      end

      // one-entry transmit buffer pulled from the queue
      if (!q_ff.buf_valid && fifo_out_valid)
      begin
         nxt_q.buf_valid = 1'b1;
         nxt_q.buf_data = fifo_out_data;
      end

      if (i_txc_clear || i_txc_irq_ack)
      begin
         nxt_q.txc = 1'b0;
      end

      case (q_ff.state)
         st_idle:
         begin
            if (q_ff.enabled && q_ff.buf_valid)
            begin
               load = 1'b1;
            end
         end
         st_shift:
         begin
            if (bit_tick)
            begin
               if (q_ff.bits_left == 4'h1)
               begin
                  if (q_ff.buf_valid)
                  begin
                     load = 1'b1;
                  end
                  else
                  begin
                     nxt_q.state = st_idle;
                     nxt_q.frame = FRAME_IDLE;
                     nxt_q.txc = 1'b1;
                  end
               end
               else
               begin
                  nxt_q.frame = {1'b1, q_ff.frame[FRAME_W-1:1]};
                  nxt_q.bits_left = q_ff.bits_left - 1'b1;
               end
            end
         end
         default:
         begin
            nxt_q.state = st_idle;
         end
      endcase

      if (load)
      begin
         nxt_q.frame = build_frame(q_ff.buf_data, i_cfg);
         nxt_q.bits_left = frame_len(i_cfg);
         nxt_q.state = st_shift;
         nxt_q.buf_valid = 1'b0;
         nxt_q.presc = i_cfg.baud_divisor;
         nxt_q.sub = 4'h0;
      end

      // clearing the enable waits for shifter, buffer and queue to drain
      if (i_cfg.transmitter_on_bit)
      begin
         nxt_q.enabled = 1'b1;
      end
      else if (q_ff.state == st_idle && !q_ff.buf_valid && !fifo_out_valid)
      begin
         nxt_q.enabled = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state register: reset leaves the line high and the pin released
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         q_ff.state <= st_idle;
         q_ff.frame <= FRAME_IDLE;
         q_ff.bits_left <= '0;
         q_ff.buf_valid <= 1'b0;
         q_ff.buf_data <= '0;
         q_ff.presc <= '0;
         q_ff.sub <= '0;
         q_ff.xck <= 1'b0;
         q_ff.txc <= 1'b0;
         q_ff.enabled <= 1'b0;
         q_ff.xck_sync <= SYNC_RESET;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_serial_out_pin = q_ff.frame[0];
   assign o_serial_out_oe = q_ff.enabled;
   assign o_transfer_clock_out = q_ff.xck;
   assign o_transfer_clock_oe = q_ff.enabled & i_cfg.sync_mode &
                                i_cfg.sync_master;
   assign o_tx_buffer_empty_flag = !q_ff.buf_valid &&
                                   !fifo_out_valid;
   assign o_tx_complete_flag = q_ff.txc;
   assign o_buffer_empty_irq = o_tx_buffer_empty_flag &
                               i_cfg.buffer_empty_irq_enable;
   assign o_tx_complete_irq = q_ff.txc & i_cfg.tx_complete_irq_enable;
   assign o_tx_active = q_ff.state == st_shift;

endmodule

// ---- serial_frame_transmitter_asserts.sv ----
`timescale 1ns/1ps
module tx_asserts (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire tx_pkg::tx_config_type i_cfg,
   input wire logic i_wr_valid,
   input wire logic o_wr_ready,
   input wire logic i_txc_clear,
   input wire logic i_txc_irq_ack,
   input wire logic o_serial_out_pin,
   input wire logic o_serial_out_oe,
   input wire logic o_tx_buffer_empty_flag,
   input wire logic o_tx_complete_flag,
   input wire logic o_buffer_empty_irq,
   input wire logic o_tx_complete_irq,
   input wire logic o_tx_active
);
   import tx_pkg::*;
   // ----
   // port relations
   // ----
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   wr_clears_empty_a: assert property
      (i_wr_valid && o_wr_ready |=> !o_tx_buffer_empty_flag)
      else $error("write left empty flag set");
   empty_irq_level_a: assert property
      (o_buffer_empty_irq == (o_tx_buffer_empty_flag
         && i_cfg.buffer_empty_irq_enable))
      else $error("empty request not a level");
   done_irq_a: assert property
      (o_tx_complete_irq == (o_tx_complete_flag
         && i_cfg.tx_complete_irq_enable))
      else $error("complete request wrong");
   done_set_a: assert property
      ($rose(o_tx_complete_flag) |-> $past(o_tx_active)
         && o_tx_buffer_empty_flag)
      else $error("complete flag set too early");
   done_clear_a: assert property
      (o_tx_complete_flag && (i_txc_clear || i_txc_irq_ack)
         && !o_tx_active |=> !o_tx_complete_flag)
      else $error("complete flag not cleared");
   idle_high_a: assert property
      (!o_tx_active |-> o_serial_out_pin)
      else $error("idle line not high");
   start_low_a: assert property
      ($rose(o_tx_active) |-> !o_serial_out_pin)
      else $error("frame without low start");
   no_gap_a: assert property
      (o_tx_active && !o_tx_buffer_empty_flag |=> o_tx_active)
      else $error("shifter idled with data waiting");
   pin_taken_a: assert property
      (i_cfg.transmitter_on_bit |=> o_serial_out_oe)
      else $error("pin not driven while enabled");
   defer_off_a: assert property
      (o_serial_out_oe && (o_tx_active || !o_tx_buffer_empty_flag)
         |=> o_serial_out_oe)
      else $error("pin released with data pending");
   pin_freed_a: assert property
      ((!i_cfg.transmitter_on_bit && !o_tx_active
         && o_tx_buffer_empty_flag) [*2] |-> !o_serial_out_oe)
      else $error("pin kept after disable");
   cover property ($rose(o_tx_active));
   cover property (i_wr_valid && !o_wr_ready);
   cover property ($rose(o_tx_complete_flag));
endmodule
bind serial_frame_transmitter tx_asserts tx_asserts_inst (.i_clk,
   .i_resetn, .i_cfg, .i_wr_valid, .o_wr_ready, .i_txc_clear,
   .i_txc_irq_ack, .o_serial_out_pin, .o_serial_out_oe,
   .o_tx_buffer_empty_flag, .o_tx_complete_flag, .o_buffer_empty_irq,
   .o_tx_complete_irq, .o_tx_active);

// ---- serial_rx_model.sv ----
`timescale 1ns/1ps
module serial_rx_model (
   input wire logic i_clk,
   input wire logic i_line,
   input wire tx_pkg::tx_config_type i_cfg,
   output logic o_got,
   output logic [8:0] o_word,
   output logic o_par,
   output logic o_stop_ok
);
   import tx_pkg::*;
   int per;
   int n;
   logic [8:0] w;
   logic p;
   logic ok;
   // ----
   // mid-bit sampler
   // ----
   initial o_got = 1'b0;
   always
   begin
      @(negedge i_line);
      per = (int'(i_cfg.baud_divisor) + 1) * (i_cfg.double_speed_bit ?
         OVERSAMPLE_DOUBLE : OVERSAMPLE_NORMAL);
      n = (i_cfg.char_size == CS_NINE) ? 9 : 5 + int'(i_cfg.char_size);
      repeat (per / 2) @(posedge i_clk);
      ok = ~i_line;
      w = 9'h000;
      p = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         repeat (per) @(posedge i_clk);
         w[i] = i_line;
      end
      if (i_cfg.parity_enable_bit)
      begin
         repeat (per) @(posedge i_clk);
         p = i_line;
      end
      // both stop bits are checked, unlike a real receiver
      for (int i = 0; i <= int'(i_cfg.two_stop); i++)
      begin
         repeat (per) @(posedge i_clk);
         ok = ok & i_line;
      end
      o_word <= w;
      o_par <= p;
      o_stop_ok <= ok;
      o_got <= 1'b1;
      @(posedge i_clk);
      o_got <= 1'b0;
   end
endmodule

// ---- serial_frame_transmitter_tb.sv ----
`timescale 1ns/1ps
module serial_frame_transmitter_tb;
   import tx_pkg::*;
   logic i_clk;
   logic i_resetn;
   tx_config_type cfg;
   logic wr_valid, ninth, txc_clear, txc_ack;
   logic [7:0] wr_data;
   logic wr_ready, pin, oe, empty, done_flag, active;
   logic got, par, stop_ok;
   logic empty_irq, done_irq, xck_oe;
   logic [8:0] d9;
   logic [8:0] word;
   logic [8:0] e;
   logic [8:0] exp_q[$];
   int fail_count = 0;
   int n_checks = 0;
   int cnt;
   // released pin has a pull-up
   wire line = oe ? pin : 1'b1;
   serial_frame_transmitter serial_frame_transmitter_inst (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_cfg(cfg),
      .i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_ready(wr_ready),
      .i_tx_ninth_bit(ninth), .i_txc_clear(txc_clear),
      .i_txc_irq_ack(txc_ack), .i_transfer_clock_pin(1'b0),
      .o_serial_out_pin(pin), .o_serial_out_oe(oe),
      .o_transfer_clock_out(), .o_transfer_clock_oe(xck_oe),
      .o_tx_buffer_empty_flag(empty), .o_tx_complete_flag(done_flag),
      .o_buffer_empty_irq(empty_irq), .o_tx_complete_irq(done_irq),
      .o_tx_active(active));
   serial_rx_model serial_rx_model_inst (.i_clk(i_clk), .i_line(line),
      .i_cfg(cfg), .o_got(got), .o_word(word), .o_par(par),
      .o_stop_ok(stop_ok));
   // ----
   // helpers
   // ----
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic chk(input logic [31:0] a, input logic [31:0] b);
      n_checks++;
      if (a !== b)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, a, b);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   function automatic logic [8:0] mask(input logic [8:0] d);
      int n;
      n = (cfg.char_size == CS_NINE) ? 9 : 5 + int'(cfg.char_size);
      return d & 9'((1 << n) - 1);
   endfunction
   // valid stays high on return so writes can run back to back
   task automatic wr(input logic [8:0] d);
      wr_valid <= 1'b1;
      wr_data <= d[7:0];
      ninth <= d[8];
      for (int k = 0; k <= 2000; k++)
      begin
         @(negedge i_clk);
         if (wr_ready === 1'b1)
            break;
         if (k == 2000)
            chk(0, 1);
         if (k == 2000)
            print_verdict();
      end
      @(posedge i_clk);
      exp_q.push_back(mask(d));
   endtask
   task automatic wait_done;
      for (int k = 0; k <= 40000; k++)
      begin
         @(negedge i_clk);
         if (exp_q.size() == 0 && done_flag === 1'b1)
            break;
         if (k == 40000)
            chk(0, 1);
         if (k == 40000)
            print_verdict();
      end
   endtask
   always @(posedge i_clk)
      if (got === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk(0, 1);
         e = exp_q.pop_front();
         chk(word, e);
         if (cfg.parity_enable_bit)
            chk(par, ^e ^ cfg.parity_odd);
         chk(stop_ok, 1);
      end
   // ----
   // scenarios
   // ----
   initial
   begin
      void'($urandom(32'h1417da95));
      i_resetn = 1'b0;
      cfg = '0;
      wr_valid = 1'b0;
      wr_data = 8'h00;
      ninth = 1'b0;
      txc_clear = 1'b0;
      txc_ack = 1'b0;
      repeat (6) @(posedge i_clk);
      i_resetn <= 1'b1;
      for (int t = 0; t < 6; t++)
      begin
         @(posedge i_clk);
         // format is fixed before the first write of each test
         cfg <= {1'b1, 2'h0, (t > 3) ? CS_NINE : 3'(t), 4'($urandom),
            1'b0, 12'($urandom % 3), 2'($urandom)};
         @(posedge i_clk);
         for (int j = 0; j < 3; j++)
            wr(9'($urandom));
         wr_valid <= 1'b0;
         wait_done();
         chk(empty, 1);
         chk(empty_irq, cfg.buffer_empty_irq_enable);
         chk(done_irq, cfg.tx_complete_irq_enable);
         chk(xck_oe, 0);
         @(posedge i_clk);
         if (t[0])
            txc_ack <= 1'b1;
         else
            txc_clear <= 1'b1;
         @(posedge i_clk);
         txc_ack <= 1'b0;
         txc_clear <= 1'b0;
         @(negedge i_clk);
         chk(done_flag, 0);
         chk(done_irq, 0);
         $display("test %0d done", t);
      end
      // fill while disabled, then let it drain with enable dropped
      @(posedge i_clk);
      cfg.transmitter_on_bit <= 1'b0;
      repeat (3) @(negedge i_clk);
      chk(oe, 0);
      @(posedge i_clk);
      for (cnt = 0; cnt < 40; cnt++)
      begin
         d9 = 9'($urandom);
         wr_valid <= 1'b1;
         wr_data <= d9[7:0];
         ninth <= d9[8];
         @(negedge i_clk);
         if (wr_ready !== 1'b1)
            break;
         @(posedge i_clk);
         exp_q.push_back(mask(d9));
      end
      @(posedge i_clk);
      wr_valid <= 1'b0;
      chk(cnt, FIFO_DEPTH + 1);
      chk(empty, 0);
      chk(empty_irq, 0);
      cfg.transmitter_on_bit <= 1'b1;
      repeat (4) @(posedge i_clk);
      cfg.transmitter_on_bit <= 1'b0;
      wait_done();
      repeat (2) @(negedge i_clk);
      chk(oe, 0);
      $display("test fill done");
      print_verdict();
   end
endmodule
